// ---- bstap_top.sv ----
// Boundary scan test access port of a synchronous memory device.
// Assumes the test clock, mode select and serial input are asynchronous
// pins sampled by ref_clk, and that pin snapshots arrive from same-clock
// logic through a valid/ready stream.
`timescale 1ns/10ps
module bstap_top (
  // Clock and reset
  input  wire logic                           ref_clk,
  input  wire logic                           reset,
  // Test link pins
  input  wire logic                           tck,
  input  wire logic                           tms,
  input  wire logic                           tdi,
  output logic                                tdo,
  output logic                                tdo_oe,
  // Pin snapshot stream
  input  wire logic                           snap_valid,
  output logic                                snap_ready,
  input  wire logic [bstap_pkg::BSR_LEN-1:0]  snap_data,
  // System side
  output logic      [bstap_pkg::BSR_LEN-1:0]  bsr_latched,
  output logic                                extest_active,
  output logic                                q_bus_oe
);

  // ==========================================================================
  // Functions
  // ==========================================================================
  // Next controller state for a sampled mode select level.
  function automatic bstap_pkg::bstap_state_e tap_next(
    input bstap_pkg::bstap_state_e st,
    input logic                    m
  );
    bstap_pkg::bstap_state_e n;
    n = bstap_pkg::ST_RESET;
    case (st)
      bstap_pkg::ST_RESET:
        n = m ? bstap_pkg::ST_RESET : bstap_pkg::ST_IDLE;
      bstap_pkg::ST_IDLE:
        n = m ? bstap_pkg::ST_SEL_DR : bstap_pkg::ST_IDLE;
      bstap_pkg::ST_SEL_DR:
        n = m ? bstap_pkg::ST_SEL_IR : bstap_pkg::ST_CAPTURE_DR;
      bstap_pkg::ST_CAPTURE_DR:
        n = m ? bstap_pkg::ST_EXIT1_DR : bstap_pkg::ST_SHIFT_DR;
      bstap_pkg::ST_SHIFT_DR:
        n = m ? bstap_pkg::ST_EXIT1_DR : bstap_pkg::ST_SHIFT_DR;
      bstap_pkg::ST_EXIT1_DR:
        n = m ? bstap_pkg::ST_UPDATE_DR : bstap_pkg::ST_PAUSE_DR;
      bstap_pkg::ST_PAUSE_DR:
        n = m ? bstap_pkg::ST_EXIT2_DR : bstap_pkg::ST_PAUSE_DR;
      bstap_pkg::ST_EXIT2_DR:
        n = m ? bstap_pkg::ST_UPDATE_DR : bstap_pkg::ST_SHIFT_DR;
      bstap_pkg::ST_UPDATE_DR:
        n = m ? bstap_pkg::ST_SEL_DR : bstap_pkg::ST_IDLE;
      bstap_pkg::ST_SEL_IR:
        n = m ? bstap_pkg::ST_RESET : bstap_pkg::ST_CAPTURE_IR;
      bstap_pkg::ST_CAPTURE_IR:
        n = m ? bstap_pkg::ST_EXIT1_IR : bstap_pkg::ST_SHIFT_IR;
      bstap_pkg::ST_SHIFT_IR:
        n = m ? bstap_pkg::ST_EXIT1_IR : bstap_pkg::ST_SHIFT_IR;
      bstap_pkg::ST_EXIT1_IR:
        n = m ? bstap_pkg::ST_UPDATE_IR : bstap_pkg::ST_PAUSE_IR;
      bstap_pkg::ST_PAUSE_IR:
        n = m ? bstap_pkg::ST_EXIT2_IR : bstap_pkg::ST_PAUSE_IR;
      bstap_pkg::ST_EXIT2_IR:
        n = m ? bstap_pkg::ST_UPDATE_IR : bstap_pkg::ST_SHIFT_IR;
      bstap_pkg::ST_UPDATE_IR:
        n = m ? bstap_pkg::ST_SEL_DR : bstap_pkg::ST_IDLE;
      default:
        n = bstap_pkg::ST_RESET;
    endcase
    return n;
  endfunction

  // True for the three instructions that select the boundary chain.
  function automatic logic uses_bsr(input logic [bstap_pkg::IR_W-1:0] ir);
    return (ir == bstap_pkg::INS_EXTEST) ||
           (ir == bstap_pkg::INS_SAMPLE_Z) ||
           (ir == bstap_pkg::INS_SAMPLE);
  endfunction

  // ==========================================================================
  // Pin sampling and test clock edges
  // ==========================================================================
  logic [bstap_pkg::SYNC_W-1:0] pins_s;
  logic                         tck_s;
  logic                         tms_s;
  logic                         tdi_s;
  logic                         tck_prev_reg;
  logic                         tck_rise;
  logic                         tck_fall;

  bstap_sync #(
    .WIDTH    (bstap_pkg::SYNC_W)
  ) u_sync (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .async_in ({tck, tms, tdi}),
    .sync_out (pins_s)
  );

  assign tck_s = pins_s[2];
  assign tms_s = pins_s[1];
  assign tdi_s = pins_s[0];

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tck_prev_reg <= 1'b0;
    end else begin
      tck_prev_reg <= tck_s;
    end
  end

  // Each detected edge is a one-cycle enable in the ref_clk domain.
  assign tck_rise = tck_s && !tck_prev_reg;
  assign tck_fall = !tck_s && tck_prev_reg;

  // ==========================================================================
  // Controller state
  // ==========================================================================
  bstap_pkg::bstap_state_e state_reg;
  bstap_pkg::bstap_state_e state_next;

  assign state_next = tap_next(state_reg, tms_s);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_reg <= bstap_pkg::ST_RESET;
    end else if (tck_rise) begin
      state_reg <= state_next;
    end
  end

  // ==========================================================================
  // Instruction register
  // ==========================================================================
  logic [bstap_pkg::IR_W-1:0] ir_shift_reg;
  logic [bstap_pkg::IR_W-1:0] ir_reg;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ir_shift_reg <= bstap_pkg::IR_CAPTURE;
    end else if (tck_rise) begin
      if (state_reg == bstap_pkg::ST_CAPTURE_IR) begin
        ir_shift_reg <= bstap_pkg::IR_CAPTURE;
      end else if (state_reg == bstap_pkg::ST_SHIFT_IR) begin
        ir_shift_reg <= {tdi_s, ir_shift_reg[bstap_pkg::IR_W-1:1]};
      end
    end
  end

  // Reserved codes are accepted as written and then select bypass.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ir_reg <= bstap_pkg::INS_IDCODE;
    end else if (state_reg == bstap_pkg::ST_RESET) begin
      ir_reg <= bstap_pkg::INS_IDCODE;
    end else if (tck_rise && state_next == bstap_pkg::ST_UPDATE_IR) begin
      ir_reg <= ir_shift_reg;
    end
  end

  // ==========================================================================
  // Data registers
  // ==========================================================================
  logic                          sel_bsr;
  logic                          sel_id;
  logic                          bypass_reg;
  logic [bstap_pkg::ID_W-1:0]    id_shift_reg;
  logic [bstap_pkg::BSR_LEN-1:0] bsr_shift_reg;
  logic [bstap_pkg::BSR_LEN-1:0] bsr_upd_reg;
  logic [bstap_pkg::BSR_LEN-1:0] snap_hold_reg;
  logic [bstap_pkg::BSR_LEN-1:0] fifo_data;
  logic                          fifo_valid;
  logic                          fifo_take;

  assign sel_bsr = uses_bsr(ir_reg);
  assign sel_id  = (ir_reg == bstap_pkg::INS_IDCODE);

  // Snapshots queue up until a capture consumes the oldest one; a capture
  // with none queued repeats the last snapshot taken.
  assign fifo_take = tck_rise && sel_bsr &&
                     (state_reg == bstap_pkg::ST_CAPTURE_DR);

  bstap_fifo #(
    .WIDTH     (bstap_pkg::BSR_LEN),
    .DEPTH     (bstap_pkg::FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .in_valid  (snap_valid),
    .in_ready  (snap_ready),
    .in_data   (snap_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_take),
    .out_data  (fifo_data)
  );

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      snap_hold_reg <= '0;
    end else if (fifo_take && fifo_valid) begin
      snap_hold_reg <= fifo_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      bypass_reg <= bstap_pkg::BYPASS_RST;
    end else if (tck_rise && !sel_bsr && !sel_id) begin
      if (state_reg == bstap_pkg::ST_CAPTURE_DR) begin
        bypass_reg <= 1'b0;
      end else if (state_reg == bstap_pkg::ST_SHIFT_DR) begin
        bypass_reg <= tdi_s;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      id_shift_reg <= '0;
    end else if (tck_rise && sel_id) begin
      if (state_reg == bstap_pkg::ST_CAPTURE_DR) begin
        id_shift_reg <= {bstap_pkg::ID_VERSION, bstap_pkg::ID_PART,
                         bstap_pkg::ID_MAKER, bstap_pkg::ID_PRESENT};
      end else if (state_reg == bstap_pkg::ST_SHIFT_DR) begin
        id_shift_reg <= {tdi_s, id_shift_reg[bstap_pkg::ID_W-1:1]};
      end
    end
  end

  // Shifting pushes old captured bits out while new preload bits enter.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      bsr_shift_reg <= '0;
    end else if (tck_rise && sel_bsr) begin
      if (state_reg == bstap_pkg::ST_CAPTURE_DR) begin
        bsr_shift_reg <= fifo_valid ? fifo_data : snap_hold_reg;
      end else if (state_reg == bstap_pkg::ST_SHIFT_DR) begin
        bsr_shift_reg <= {tdi_s,
                          bsr_shift_reg[bstap_pkg::BSR_LEN-1:1]};
      end
    end
  end

  // High-impedance sample also loads the parallel stage; only external
  // test lets it reach the pins.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      bsr_upd_reg <= bstap_pkg::BSR_UPD_RST;
    end else if (state_reg == bstap_pkg::ST_RESET) begin
      bsr_upd_reg[bstap_pkg::OE_CELL] <= 1'b1;
    end else if (tck_rise && sel_bsr &&
                 state_next == bstap_pkg::ST_UPDATE_DR) begin
      bsr_upd_reg <= bsr_shift_reg;
    end
  end

  // ==========================================================================
  // Serial output and system side
  // ==========================================================================
  logic tdo_next;
  logic shifting;

  assign shifting = (state_reg == bstap_pkg::ST_SHIFT_DR) ||
                    (state_reg == bstap_pkg::ST_SHIFT_IR);

  always_comb begin
    if (state_reg == bstap_pkg::ST_SHIFT_IR) begin
      tdo_next = ir_shift_reg[0];
    end else if (sel_bsr) begin
      tdo_next = bsr_shift_reg[0];
    end else if (sel_id) begin
      tdo_next = id_shift_reg[0];
    end else begin
      tdo_next = bypass_reg;
    end
  end

  // The pin changes only on falling test clock, so the far end's rising
  // sample always sees a settled level.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo    <= tdo_next;
      tdo_oe <= shifting;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      q_bus_oe      <= 1'b1;
      extest_active <= 1'b0;
    end else begin
      extest_active <= (ir_reg == bstap_pkg::INS_EXTEST);
      if (ir_reg == bstap_pkg::INS_SAMPLE_Z) begin
        q_bus_oe <= 1'b0;
      end else if (ir_reg == bstap_pkg::INS_EXTEST) begin
        q_bus_oe <= bsr_upd_reg[bstap_pkg::OE_CELL];
      end else begin
        q_bus_oe <= 1'b1;
      end
    end
  end

  assign bsr_latched = bsr_upd_reg;

endmodule

// ---- bstap_pkg.sv ----
// Shared constants and types of the boundary scan test access port.
// Assumes a single system clock that oversamples the test clock pins.
package bstap_pkg;

  // ==========================================================================
  // Register sizes and fixed patterns
  // ==========================================================================
  localparam int          IR_W        = 3;
  localparam int          ID_W        = 32;
  localparam int          BSR_LEN     = 109;
  localparam int          OE_CELL     = 108;
  localparam int          FIFO_DEPTH  = 16;
  localparam int          SYNC_W      = 3;
  localparam logic [IR_W-1:0] IR_CAPTURE = 3'h1;

  // Instruction codes.
  localparam logic [IR_W-1:0] INS_EXTEST   = 3'h0;
  localparam logic [IR_W-1:0] INS_IDCODE   = 3'h1;
  localparam logic [IR_W-1:0] INS_SAMPLE_Z = 3'h2;
  localparam logic [IR_W-1:0] INS_SAMPLE   = 3'h4;
  localparam logic [IR_W-1:0] INS_BYPASS   = 3'h7;

  // Identification word fields; device and maker values are arbitrary.
  localparam logic [2:0]  ID_VERSION  = 3'h0;
  localparam logic [16:0] ID_PART     = 17'h0A5A5;
  localparam logic [10:0] ID_MAKER    = 11'h2A5;
  localparam logic        ID_PRESENT  = 1'h1;

  // Values after reset.
  localparam logic [BSR_LEN-1:0] BSR_UPD_RST = {1'b1, {(BSR_LEN-1){1'b0}}};
  localparam logic               BYPASS_RST  = 1'h0;

  // ==========================================================================
  // Test controller states
  // ==========================================================================
  typedef enum logic [15:0] {
    ST_RESET      = 16'h0001,
    ST_IDLE       = 16'h0002,
    ST_SEL_DR     = 16'h0004,
    ST_CAPTURE_DR = 16'h0008,
    ST_SHIFT_DR   = 16'h0010,
    ST_EXIT1_DR   = 16'h0020,
    ST_PAUSE_DR   = 16'h0040,
    ST_EXIT2_DR   = 16'h0080,
    ST_UPDATE_DR  = 16'h0100,
    ST_SEL_IR     = 16'h0200,
    ST_CAPTURE_IR = 16'h0400,
    ST_SHIFT_IR   = 16'h0800,
    ST_EXIT1_IR   = 16'h1000,
    ST_PAUSE_IR   = 16'h2000,
    ST_EXIT2_IR   = 16'h4000,
    ST_UPDATE_IR  = 16'h8000
  } bstap_state_e;

endpackage

// ---- bstap_sync.sv ----
// Two-stage synchroniser for a group of slow external levels.
// Assumes inputs change no faster than a few system clock periods.
`timescale 1ns/10ps
module bstap_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             reset,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // The first stage feeds only the second one.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

// ---- bstap_fifo.sv ----
// First-in first-out buffer with valid and ready on both sides.
// Assumes DEPTH is a power of two.
`timescale 1ns/10ps
module bstap_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             reset,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;
  logic             push;
  logic             pop;

  // An extra pointer bit tells full from empty.
  assign out_valid = (wr_ptr_reg != rd_ptr_reg);
  assign in_ready  = (wr_ptr_reg[AW-1:0] != rd_ptr_reg[AW-1:0]) ||
                     (wr_ptr_reg[AW] == rd_ptr_reg[AW]);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr_reg[AW-1:0]];

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wr_ptr_reg <= '0;
    end else if (push) begin
      wr_ptr_reg <= wr_ptr_reg + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rd_ptr_reg <= '0;
    end else if (pop) begin
      rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end

endmodule

// ---- bstap_monitor.sv ----
// Concurrent checks on the pins and outputs of the test access port.
// Assumes it is bound into bstap_top and that ref_clk is the only domain.
`timescale 1ns/10ps
module bstap_monitor (
  // Clock and reset
  input wire logic                          ref_clk,
  input wire logic                          reset,
  // Test link
  input wire logic                          tck,
  input wire logic                          tms,
  input wire logic                          tdo,
  input wire logic                          tdo_oe,
  // Snapshot stream and system side
  input wire logic                          snap_ready,
  input wire logic [bstap_pkg::BSR_LEN-1:0] bsr_latched,
  input wire logic                          extest_active,
  input wire logic                          q_bus_oe
);
  default clocking mon_cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  // ==========
  // Run of test clock rises with mode select high
  // ==========
  logic       tck_reg;
  logic [2:0] ones_reg;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tck_reg  <= 1'b0;
      ones_reg <= 3'h0;
    end else begin
      tck_reg <= tck;
      if (tck && !tck_reg) begin
        if (!tms) ones_reg <= 3'h0;
        else if (ones_reg != 3'h5) ones_reg <= ones_reg + 3'h1;
      end
    end
  end

  // ==========
  // Properties
  // ==========
  // The raw pin is seen before the design's synchroniser, hence a window.
  sequence s_tlr_seen;
    $rose(ones_reg == 3'h5);
  endsequence
  sequence s_tlr_state;
    !extest_active && bsr_latched[bstap_pkg::OE_CELL] && q_bus_oe;
  endsequence
  property p_tlr_return;
    s_tlr_seen |-> ##[1:8] s_tlr_state;
  endproperty
  property p_rst_vals;
    $fell(reset) |-> q_bus_oe && !extest_active && !tdo_oe && snap_ready
      && bsr_latched == bstap_pkg::BSR_UPD_RST;
  endproperty
  property p_tdo_fall;
    $changed(tdo) |-> !tck && !$past(tck);
  endproperty
  property p_tdo_hold;
    $changed(tdo) |=> $stable(tdo) [*6];
  endproperty
  property p_oe_hold;
    $changed(tdo_oe) |=> $stable(tdo_oe) [*6];
  endproperty
  property p_ext_en;
    extest_active && $past(extest_active)
      && $stable(bsr_latched[bstap_pkg::OE_CELL])
      |-> q_bus_oe == bsr_latched[bstap_pkg::OE_CELL];
  endproperty
  property p_bsr_upd;
    $changed(bsr_latched) |-> !tdo_oe && !$past(tdo_oe);
  endproperty
  property p_ins_upd;
    $changed(extest_active) |-> !tdo_oe && !$past(tdo_oe);
  endproperty
  property p_hiz_hold;
    $changed(q_bus_oe) |-> !tdo_oe && !$past(tdo_oe);
  endproperty

  a_tlr_return: assert property (p_tlr_return)
    else $error("No return to reset after five mode select ones");
  a_rst_vals: assert property (p_rst_vals)
    else $error("Wrong output values after reset");
  a_tdo_fall: assert property (p_tdo_fall)
    else $error("Serial output moved outside the clock low phase");
  a_tdo_hold: assert property (p_tdo_hold)
    else $error("Serial output changed twice in one test clock");
  a_oe_hold: assert property (p_oe_hold)
    else $error("Serial enable changed twice in one test clock");
  a_ext_en: assert property (p_ext_en)
    else $error("Read bus enable differs from the enable cell");
  a_bsr_upd: assert property (p_bsr_upd)
    else $error("Parallel cells changed while shifting");
  a_ins_upd: assert property (p_ins_upd)
    else $error("Instruction took effect while shifting");
  a_hiz_hold: assert property (p_hiz_hold)
    else $error("Read bus enable changed while shifting");
endmodule

bind bstap_top bstap_monitor bstap_monitor_i (
  .ref_clk(ref_clk), .reset(reset), .tck(tck), .tms(tms), .tdo(tdo),
  .tdo_oe(tdo_oe), .snap_ready(snap_ready), .bsr_latched(bsr_latched),
  .extest_active(extest_active), .q_bus_oe(q_bus_oe));

// ---- bstap_jtag.sv ----
// Behavioural external test controller that drives the test link pins.
// Assumes scans start in Run-Test/Idle; the test clock idles low.
`timescale 1ns/10ps
module bstap_jtag (
  // Clock
  input  wire logic                          ref_clk,
  // Test link
  output logic                               tck,
  output logic                               tms,
  output logic                               tdi,
  input  wire logic                          tdo,
  // Scan result, bit n is the n-th bit shifted out
  output logic                               res_valid,
  output logic      [bstap_pkg::BSR_LEN-1:0] res_data
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    res_valid = 1'b0;
    res_data = '0;
  end

  // ==========
  // One test clock: 200 ns low, 120 ns high
  // ==========
  // The low phase is the longer one so the output is settled when read.
  task automatic step(input logic m, input logic d, output logic o);
    @(negedge ref_clk);
    tms = m;
    tdi = d;
    repeat (4) @(negedge ref_clk);
    o = tdo;
    tck = 1'b1;
    repeat (3) @(negedge ref_clk);
    tck = 1'b0;
    tdi = ~d;
  endtask

  task automatic tlr();
    logic o;
    repeat (5) step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
  endtask

  // Walks idle, select, capture, shift, exit, update and back to idle.
  task automatic scan(input logic ir, input int n,
                      input logic [bstap_pkg::BSR_LEN-1:0] din);
    logic o;
    res_data = '0;
    step(1'b1, 1'b0, o);
    if (ir) step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
    step(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o);
      res_data[i] = o;
    end
    step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
    @(negedge ref_clk);
    res_valid = 1'b1;
    @(negedge ref_clk);
    res_valid = 1'b0;
  endtask
endmodule

// ---- tb_top.sv ----
// Self-checking bench for the boundary scan test access port.
// Assumes bstap_top, the bstap_jtag model and the bound monitor.
`timescale 1ns/10ps
module tb_top;
  localparam int BL = bstap_pkg::BSR_LEN;
  localparam logic [31:0] ID_WORD = {bstap_pkg::ID_VERSION,
    bstap_pkg::ID_PART, bstap_pkg::ID_MAKER, bstap_pkg::ID_PRESENT};
  localparam int TIMEOUT = 60000;

  logic          ref_clk = 1'b0;
  logic          reset = 1'b1;
  logic          snap_valid = 1'b0;
  logic [BL-1:0] snap_data = '0;
  logic          snap_ready;
  logic          tck;
  logic          tms;
  logic          tdi;
  logic          tdo;
  logic          tdo_oe;
  wire           tdo_pin;
  logic [BL-1:0] bsr_latched;
  logic          extest_active;
  logic          q_bus_oe;
  logic          res_valid;
  logic [BL-1:0] res_data;
  logic [BL-1:0] exp_q[$];
  logic [BL-1:0] fw[16];
  logic [BL-1:0] exp_bsr;
  logic [BL-1:0] w;
  logic [BL-1:0] p;
  logic [31:0]   lfsr_reg;
  logic [2:0]    code;
  logic          bnd;
  int            bad_count = 0;
  int            comparisons = 0;
  int            cycles = 0;

  always #20 ref_clk = ~ref_clk;
  assign tdo_pin = tdo_oe ? tdo : 1'bz;

  bstap_top bstap_top_i (.ref_clk(ref_clk), .reset(reset), .tck(tck),
    .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
    .snap_valid(snap_valid), .snap_ready(snap_ready),
    .snap_data(snap_data), .bsr_latched(bsr_latched),
    .extest_active(extest_active), .q_bus_oe(q_bus_oe));
  bstap_jtag bstap_jtag_i (.ref_clk(ref_clk), .tck(tck), .tms(tms),
    .tdi(tdi), .tdo(tdo_pin), .res_valid(res_valid), .res_data(res_data));

  // ==========
  // Checking and reporting
  // ==========
  task automatic check_vec(input logic [BL-1:0] got, input logic [BL-1:0] ex);
    comparisons++;
    if (got !== ex) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, ex);
    end
  endtask

  task automatic check_bit(input logic got, input logic ex);
    comparisons++;
    if (got !== ex) begin
      bad_count++;
      $display("CHECK FAILED at %0t: flag %b expected %b", $time, got, ex);
    end
  endtask

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    if (res_valid === 1'b1) begin
      if (exp_q.size() == 0) check_bit(1'b1, 1'b0);
      else check_vec(res_data, exp_q.pop_front());
    end
  end

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == TIMEOUT) begin
      bad_count++;
      stop_test();
    end
  end

  // ==========
  // Stimulus
  // ==========
  function automatic logic [BL-1:0] rnd();
    logic [127:0] t;
    for (int i = 0; i < 4; i++) begin
      lfsr_reg = {lfsr_reg[30:0],
                  lfsr_reg[31] ^ lfsr_reg[21] ^ lfsr_reg[1] ^ lfsr_reg[0]};
      t = {t[95:0], lfsr_reg};
    end
    return t[BL-1:0];
  endfunction

  // The offer stands until there is room; a queued word then waits for a
  // capture, so it is stable there.
  task automatic push(input logic [BL-1:0] d);
    @(negedge ref_clk);
    snap_valid = 1'b1;
    snap_data = d;
    while (snap_ready !== 1'b1) @(negedge ref_clk);
    @(negedge ref_clk);
    snap_valid = 1'b0;
    snap_data = ~d;
  endtask

  task automatic ir(input logic [2:0] c);
    exp_q.push_back(BL'(3'h1));
    bstap_jtag_i.scan(1'b1, 3, BL'(c));
  endtask

  task automatic dr(input int n, input logic [BL-1:0] d,
                    input logic [BL-1:0] ex);
    exp_q.push_back(ex);
    bstap_jtag_i.scan(1'b0, n, d);
  endtask

  initial begin
    lfsr_reg = 32'h4C22;
    exp_bsr = bstap_pkg::BSR_UPD_RST;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    reset = 1'b0;
    check_bit(q_bus_oe, 1'b1);
    check_bit(extest_active, 1'b0);
    check_vec(bsr_latched, bstap_pkg::BSR_UPD_RST);
    bstap_jtag_i.tlr();
    dr(32, rnd(), BL'(ID_WORD));
    // Every implemented code in turn; the reserved ones are never loaded.
    for (int c = 0; c < 8; c++) begin
      if (c inside {3, 5, 6}) continue;
      code = c[2:0];
      bnd = code inside {bstap_pkg::INS_EXTEST, bstap_pkg::INS_SAMPLE_Z,
                         bstap_pkg::INS_SAMPLE};
      w = rnd();
      p = rnd();
      p[BL-1] = (code != bstap_pkg::INS_EXTEST);
      if (bnd) push(w);
      ir(code);
      check_bit(q_bus_oe, code != bstap_pkg::INS_SAMPLE_Z);
      check_bit(extest_active, code == 3'h0);
      if (bnd) exp_bsr = p;
      if (bnd) dr(BL, p, w);
      else if (code == 3'h1) dr(BL, p, {p[76:0], ID_WORD});
      else dr(BL, p, {p[BL-2:0], 1'b0});
      check_vec(bsr_latched, exp_bsr);
      check_bit(q_bus_oe, !(code == 3'h0 || code == 3'h2));
    end
    for (int i = 0; i < 16; i++) begin
      fw[i] = rnd();
      push(fw[i]);
    end
    check_bit(snap_ready, 1'b0);
    w = rnd();
    ir(bstap_pkg::INS_SAMPLE);
    // The extra offer is held until the first capture makes room.
    fork
      push(w);
      for (int i = 0; i < 16; i++) dr(BL, rnd(), fw[i]);
    join
    dr(BL, rnd(), w);
    p = rnd();
    p[BL-1] = 1'b0;
    dr(BL, p, w);
    check_bit(snap_ready, 1'b1);
    ir(bstap_pkg::INS_EXTEST);
    check_bit(q_bus_oe, 1'b0);
    bstap_jtag_i.tlr();
    check_bit(extest_active, 1'b0);
    check_bit(bsr_latched[BL-1], 1'b1);
    check_bit(q_bus_oe, 1'b1);
    dr(32, rnd(), BL'(ID_WORD));
    check_bit(exp_q.size() == 0, 1'b1);
    stop_test();
  end
endmodule
